// *** serdes_link.sv ***
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Every frame starts with a one bit and ends with a zero bit.
// - Twenty serial bits go out per transmit word clock period.
// - Parallel input is captured at each rising transmit word clock edge.
// - Pattern request held six word clocks stops capture; training patterns go out.
// - After transmit lock, pattern request high sends training patterns.
// - Training pattern is nine ones then nine zeros, normally framed.
// - Serial output stays off until transmit PLL has locked.
// - Receive outputs off while PLL locks; lock indicator high until locked.
// - Receiver finds the stop-to-start edge to lock.
// - Lock indicator falls in the cycle valid data first appears.
// - Parallel output is valid only while lock indicator is low.
// - Recovered word clock is driven alongside the recovered word.
// - Two missed frame edges drop lock; receiver then searches again.
// - Several candidate edges per frame over many frames block lock.
// - Receive output enable gates data and recovered clock outputs.
// - Enable low floats outputs; high restores prior state.
// - Receive sleep stops PLL, floats outputs and serial input.
// - Leaving receive sleep restarts initialization and relock.
// - Transmit sleep stops PLL and floats serial output.
// - Leaving transmit sleep relocks PLL before sending.
module serdes_link #(
   parameter int PLL_CYCLES = serdes_pkg::PLL_LOCK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   // Transmit side
   input  wire logic        tx_word_clock,
   input  wire logic [17:0] tx_word_in,
   input  wire logic        sync_request,
   input  wire logic        tx_sleep_n,
   input  wire logic        tx_bit_strobe,
   output logic             tx_serial,
   output logic             tx_serial_oe,
   // Receive side
   input  wire logic        rx_local_clock,
   input  wire logic        rx_serial,
   input  wire logic        rx_bit_strobe,
   input  wire logic        rx_out_enable,
   input  wire logic        rx_sleep_n,
   output logic [17:0]      rx_word_out,
   output logic             rx_word_oe,
   output logic             rx_word_clock,
   output logic             rx_clock_oe,
   output logic             rx_lock_n,
   output logic             rx_serial_term,
   output logic             multi_edge_pattern
);
   localparam int FB = serdes_pkg::FRAME_BITS;

   // Pin inputs through two flops
   logic wclk_s, sync_s, txsl_s, rclk_s, rxd_s, rxsl_s, roe_s, txb_s, rxb_s;
   logic [17:0] data_s;
   sync2 u_s0 (.clk(clk), .rst(rst), .d(tx_word_clock),  .q(wclk_s));
   sync2 u_s1 (.clk(clk), .rst(rst), .d(sync_request),   .q(sync_s));
   sync2 u_s2 (.clk(clk), .rst(rst), .d(tx_sleep_n),     .q(txsl_s));
   sync2 u_s3 (.clk(clk), .rst(rst), .d(rx_local_clock), .q(rclk_s));
   sync2 u_s4 (.clk(clk), .rst(rst), .d(rx_serial),      .q(rxd_s));
   sync2 u_s5 (.clk(clk), .rst(rst), .d(rx_sleep_n),     .q(rxsl_s));
   sync2 u_s6 (.clk(clk), .rst(rst), .d(rx_out_enable),  .q(roe_s));
   sync2 u_s7 (.clk(clk), .rst(rst), .d(tx_bit_strobe),  .q(txb_s));
   sync2 u_s8 (.clk(clk), .rst(rst), .d(rx_bit_strobe),  .q(rxb_s));
   genvar gi;
   generate
      for (gi = 0; gi < 18; gi++) begin : g_data
         sync2 u_d (.clk(clk), .rst(rst), .d(tx_word_in[gi]), .q(data_s[gi]));
      end
   endgenerate

   // Edge finders on synchronised clocks and strobes
   logic wclk_q, rclk_q, txb_q, rxb_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         wclk_q <= 1'b0;
         rclk_q <= 1'b0;
         txb_q  <= 1'b0;
         rxb_q  <= 1'b0;
      end else begin
         wclk_q <= wclk_s;
         rclk_q <= rclk_s;
         txb_q  <= txb_s;
         rxb_q  <= rxb_s;
      end
   end
   wire wclk_rise = wclk_s & ~wclk_q;
   wire rclk_rise = rclk_s & ~rclk_q;
   // Bit slots come from a 20x word-rate strobe supplied outside
   wire tx_bit    = txb_s & ~txb_q;
   wire rx_bit    = rxb_s & ~rxb_q;

   // ---------------- Transmitter ----------------
   logic tx_locked;
   pll_lock #(.CYCLES(PLL_CYCLES)) u_txpll (
      .clk(clk), .rst(rst), .run(txsl_s), .ref_edge(wclk_rise),
      .locked(tx_locked)
   );

   logic [2:0]  sync_cnt;
   logic        sync_mode;
   always_ff @(posedge clk) begin
      if (rst || !sync_s) begin
         sync_cnt  <= '0;
         sync_mode <= 1'b0;
      end else if (wclk_rise && tx_locked) begin
         if (sync_cnt != 3'(serdes_pkg::SYNC_HOLD)) sync_cnt <= sync_cnt + 3'h1;
         sync_mode <= 1'b1;
      end
   end

   // Word latch; held while pattern requested long enough
   logic [17:0] tx_hold;
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_hold <= serdes_pkg::WORD_RESET;
      end else if (wclk_rise && !(sync_s && sync_cnt == 3'(serdes_pkg::SYNC_HOLD))) begin
         tx_hold <= data_s;
      end
   end

   logic [FB-1:0] tx_shift;
   logic [4:0]    tx_left;
   always_ff @(posedge clk) begin
      if (rst || !tx_locked) begin
         tx_shift <= '0;
         tx_left  <= '0;
      end else if (wclk_rise) begin
         // Frame sent LSB first: start, bit0..bit17, stop
         tx_shift <= {serdes_pkg::STOP_BIT,
                      (sync_mode ? serdes_pkg::SYNC_WORD : tx_hold),
                      serdes_pkg::START_BIT};
         tx_left  <= 5'(FB);
      end else if (tx_bit && tx_left != 5'h00) begin
         tx_shift <= {1'b0, tx_shift[FB-1:1]};
         tx_left  <= tx_left - 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_serial    <= 1'b0;
         tx_serial_oe <= 1'b0;
      end else begin
         tx_serial    <= tx_shift[0];
         tx_serial_oe <= tx_locked & txsl_s;
      end
   end

   // ---------------- Receiver ----------------
   logic rx_pll_locked;
   pll_lock #(.CYCLES(PLL_CYCLES)) u_rxpll (
      .clk(clk), .rst(rst), .run(rxsl_s), .ref_edge(rclk_rise),
      .locked(rx_pll_locked)
   );

   logic [FB-1:0] rx_win;
   logic          rx_prev;
   always_ff @(posedge clk) begin
      if (rst || !rxsl_s) begin
         rx_win  <= '0;
         rx_prev <= 1'b0;
      end else if (rx_bit) begin
         rx_win  <= {rxd_s, rx_win[FB-1:1]};
         rx_prev <= rxd_s;
      end
   end

   // Position within frame; zero marks the stop-to-start edge slot
   logic [4:0] rx_pos;
   logic [4:0] cand_cnt;
   logic [1:0] miss_cnt;
   logic [2:0] good_cnt;
   logic [2:0] repeat_cnt;
   logic       acquired;
   logic       hunt;
   wire        rise      = rx_bit && !rx_prev && rxd_s;
   wire        frame_end = rx_bit && !hunt && rx_pos == 5'(FB - 1);
   // Frame as it stands once the current sample is shifted in
   wire [FB-1:0] rx_frame = {rxd_s, rx_win[FB-1:1]};
   wire        framed    = rx_frame[0] == serdes_pkg::START_BIT &&
                           rx_frame[FB-1] == serdes_pkg::STOP_BIT;

   always_ff @(posedge clk) begin
      if (rst || !rxsl_s || !rx_pll_locked) begin
         rx_pos     <= '0;
         cand_cnt   <= '0;
         miss_cnt   <= '0;
         good_cnt   <= '0;
         repeat_cnt <= '0;
         acquired   <= 1'b0;
         hunt       <= 1'b1;
      end else if (!acquired) begin
         // One rising edge is taken as slot zero; only whole frames move it again
         if (rx_bit) begin
            if (hunt && rise) begin
               rx_pos   <= 5'h01;
               hunt     <= 1'b0;
               cand_cnt <= '0;
            end else begin
               rx_pos <= (rx_pos == 5'(FB - 1)) ? 5'h00 : rx_pos + 5'h01;
            end
         end
         if (!hunt && rise && rx_pos != 5'h00 && cand_cnt != 5'h1F) begin
            cand_cnt <= cand_cnt + 5'h01;
         end
         if (frame_end) begin
            cand_cnt <= '0;
            if (!framed) begin
               // No edge at slot zero: give up this alignment
               good_cnt   <= '0;
               repeat_cnt <= '0;
               hunt       <= 1'b1;
            end else if (cand_cnt != 5'h00) begin
               // Extra edges inside a framed window: repetitive pattern
               good_cnt <= '0;
               if (repeat_cnt != 3'(serdes_pkg::REPEAT_FRAMES)) begin
                  repeat_cnt <= repeat_cnt + 3'h1;
               end
            end else begin
               repeat_cnt <= '0;
               if (good_cnt == 3'(serdes_pkg::LOCK_FRAMES - 1)) acquired <= 1'b1;
               good_cnt <= good_cnt + 3'h1;
            end
         end
      end else begin
         if (rx_bit) rx_pos <= (rx_pos == 5'(FB - 1)) ? 5'h00 : rx_pos + 5'h01;
         if (frame_end) begin
            if (framed) begin
               miss_cnt <= '0;
            end else if (miss_cnt == 2'(serdes_pkg::MISS_LIMIT - 1)) begin
               acquired <= 1'b0;
               good_cnt <= '0;
               miss_cnt <= '0;
               hunt     <= 1'b1;
            end else begin
               miss_cnt <= miss_cnt + 2'h1;
            end
         end
      end
   end

   // Output word and lock change together at frame end
   logic [17:0] rx_word;
   logic        rx_valid;
   logic        rx_phase;
   always_ff @(posedge clk) begin
      if (rst || !rxsl_s) begin
         rx_word  <= serdes_pkg::WORD_RESET;
         rx_valid <= 1'b0;
         rx_phase <= 1'b0;
      end else begin
         if (frame_end) begin
            rx_word  <= rx_frame[FB-2:1];
            rx_valid <= acquired;
            rx_phase <= 1'b1;
         end else if (rx_bit && rx_pos == 5'(FB / 2 - 1)) begin
            rx_phase <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_word_out        <= serdes_pkg::WORD_RESET;
         rx_word_clock      <= 1'b0;
         rx_lock_n          <= 1'b1;
         rx_word_oe         <= 1'b0;
         rx_clock_oe        <= 1'b0;
         rx_serial_term     <= 1'b0;
         multi_edge_pattern <= 1'b0;
      end else begin
         rx_word_out        <= rx_word;
         rx_word_clock      <= rx_phase;
         // Sleep drops lock in the same cycle as the serial input is released
         rx_lock_n          <= ~(rx_valid & acquired & rxsl_s);
         // Enable returns to whatever state logic holds underneath
         rx_word_oe         <= roe_s & rxsl_s & rx_pll_locked;
         rx_clock_oe        <= roe_s & rxsl_s & rx_pll_locked;
         rx_serial_term     <= rxsl_s;
         multi_edge_pattern <= (repeat_cnt == 3'(serdes_pkg::REPEAT_FRAMES));
      end
   end
endmodule // serdes_link
`default_nettype wire

// *** serdes_pkg.sv ***
package serdes_pkg;
   localparam int WORD_BITS       = 18;
   localparam int FRAME_BITS      = 20;
   localparam int SYNC_HOLD       = 6;
   localparam int MISS_LIMIT      = 2;
   localparam int PLL_LOCK_CYCLES = 510;
   localparam int REPEAT_FRAMES   = 4;
   localparam int LOCK_FRAMES     = 4;
   localparam logic START_BIT     = 1'b1;
   localparam logic STOP_BIT      = 1'b0;
   // Bits 0..8 go out first, so the nine ones lead the nine zeros on the line
   localparam logic [17:0] SYNC_WORD = 18'h001FF;
   localparam logic [17:0] WORD_RESET = 18'h00000;
endpackage

// *** sync2.sv ***
`timescale 1ns/1ns
`default_nettype none
module sync2 (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic d,
   output var  logic q
);
   logic meta;
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b0;
         q    <= 1'b0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // sync2
`default_nettype wire

// *** pll_lock.sv ***
`timescale 1ns/1ns
`default_nettype none
// Models a PLL acquiring lock: counts reference edges while running.
module pll_lock #(
   parameter int CYCLES = serdes_pkg::PLL_LOCK_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic run,
   input  wire logic ref_edge,
   output var  logic locked
);
   if (CYCLES < 1) begin : g_bad_cycles
      $error("pll_lock: CYCLES must be positive");
   end
   logic [$clog2(CYCLES+1)-1:0] count;
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         count  <= '0;
         locked <= 1'b0;
      end else if (ref_edge && !locked) begin
         if (count == ($clog2(CYCLES+1))'(CYCLES - 1)) locked <= 1'b1;
         count <= count + 1'b1;
      end
   end
endmodule // pll_lock
`default_nettype wire

// *** serdes_link_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module serdes_link_props #(
   parameter int PLL_CYCLES = serdes_pkg::PLL_LOCK_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins driven from outside
   input wire logic tx_word_clock,
   input wire logic tx_sleep_n,
   input wire logic rx_serial,
   input wire logic rx_bit_strobe,
   input wire logic rx_out_enable,
   input wire logic rx_sleep_n,
   // Pins driven by the block
   input wire logic tx_serial_oe,
   input wire logic rx_word_oe,
   input wire logic rx_word_clock,
   input wire logic rx_clock_oe,
   input wire logic rx_lock_n,
   input wire logic rx_serial_term,
   input wire logic multi_edge_pattern
);
   logic       wc_d;
   logic       bs_d;
   logic       rs_d;
   logic [9:0] rises;
   logic [6:0] stuck;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Raw pin edges lead the design's synchronisers, so this count is never short
   always_ff @(posedge clk) begin
      wc_d <= tx_word_clock;
      if (rst || !tx_sleep_n) begin
         rises <= '0;
      end else if (tx_word_clock && !wc_d && rises != 10'h3FF) begin
         rises <= rises + 10'h001;
      end
   end

   // Bit slots seen with no change on the incoming line
   always_ff @(posedge clk) begin
      bs_d <= rx_bit_strobe;
      rs_d <= rx_serial;
      if (rst || rx_serial != rs_d) begin
         stuck <= '0;
      end else if (rx_bit_strobe && !bs_d && stuck != 7'h7F) begin
         stuck <= stuck + 7'h01;
      end
   end

   sequence s_tx_off;
      !tx_sleep_n [*5];
   endsequence

   sequence s_rx_off;
      !rx_sleep_n [*5];
   endsequence

   a_reset_quiet: assert property ($fell(rst) |-> rx_lock_n && !tx_serial_oe)
      else $error("outputs active right after reset");
   a_tx_pll_wait: assert property ($rose(tx_serial_oe) |-> int'(rises) >= PLL_CYCLES)
      else $error("serial output enabled before word clock lock");
   a_tx_sleep_float: assert property (s_tx_off |-> !tx_serial_oe)
      else $error("serial output driven while transmit asleep");
   a_rx_sleep_float: assert property (s_rx_off |-> !rx_serial_term && !rx_word_oe
                                      && !rx_clock_oe && rx_lock_n)
      else $error("receive side active while asleep");
   a_enable_gates: assert property (!rx_out_enable [*5] |-> !rx_word_oe && !rx_clock_oe)
      else $error("receive outputs driven while disabled");
   a_lock_with_word: assert property ($fell(rx_lock_n) |-> rx_word_clock)
      else $error("lock asserted without a recovered word");
   a_repeat_no_lock: assert property (multi_edge_pattern && $past(rx_lock_n) |-> rx_lock_n)
      else $error("lock taken on a repetitive pattern");
   // A frame can still pass 19 slots after the last change, then two must miss
   a_stuck_unlocks: assert property (stuck > 7'h3F |-> rx_lock_n)
      else $error("lock kept with no frame edges");
   a_lock_needs_term: assert property (!rx_lock_n |-> rx_serial_term)
      else $error("lock shown with serial input off");
endmodule // serdes_link_props
bind serdes_link serdes_link_props #(.PLL_CYCLES(PLL_CYCLES)) i_props (
   .clk, .rst, .tx_word_clock, .tx_sleep_n, .rx_serial, .rx_bit_strobe,
   .rx_out_enable, .rx_sleep_n, .tx_serial_oe, .rx_word_oe, .rx_word_clock,
   .rx_clock_oe, .rx_lock_n, .rx_serial_term, .multi_edge_pattern
);
`default_nettype wire

// *** far_end_loop.sv ***
`timescale 1ns/1ns
`default_nettype none
// Far device in line loopback: returns our serial stream one bit later
module far_end_loop (
   // Line from the local transmitter
   input  wire logic line_in,
   input  wire logic line_oe,
   input  wire logic bit_clk,
   // Line back to the local receiver
   output var  logic line_out,
   output wire logic bit_out
);
   logic last = 1'b0;

   // Data moves at the strobe's fall so it is steady at the rise
   assign bit_out = ~bit_clk;

   // A released line must not look like its old level, so it shows the inverse
   always @(posedge bit_clk) begin
      line_out <= line_oe ? line_in : ~last;
      if (line_oe) begin
         last <= line_in;
      end
   end
endmodule // far_end_loop
`default_nettype wire

// *** serdes_link_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module serdes_link_test;
   localparam int PLL = 4;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        tx_word_clock = 1'b0;
   logic        tx_bit_strobe = 1'b0;
   logic [17:0] tx_word_in = 18'h00000;
   logic        sync_request = 1'b0;
   logic        tx_sleep_n = 1'b1;
   logic        rx_out_enable = 1'b1;
   logic        rx_sleep_n = 1'b1;
   logic        tx_serial;
   logic        tx_serial_oe;
   logic        rx_serial;
   logic        rx_bit_strobe;
   logic [17:0] rx_word_out;
   logic        rx_word_oe;
   logic        rx_word_clock;
   logic        rx_clock_oe;
   logic        rx_lock_n;
   logic        rx_serial_term;
   logic        multi_edge_pattern;
   logic [3:0]  bits = 4'h0;
   logic [17:0] tab [3] = '{18'h00001, 18'h3FFFF, 18'h0000F};
   int          err_count = 0;
   int          compares = 0;

   serdes_link #(.PLL_CYCLES(PLL)) i_dut (
      .clk, .rst, .tx_word_clock, .tx_word_in, .sync_request, .tx_sleep_n,
      .tx_bit_strobe, .tx_serial, .tx_serial_oe, .rx_local_clock(tx_word_clock),
      .rx_serial, .rx_bit_strobe, .rx_out_enable, .rx_sleep_n, .rx_word_out,
      .rx_word_oe, .rx_word_clock, .rx_clock_oe, .rx_lock_n, .rx_serial_term,
      .multi_edge_pattern
   );

   far_end_loop i_far (.line_in(tx_serial), .line_oe(tx_serial_oe),
      .bit_clk(tx_bit_strobe), .line_out(rx_serial), .bit_out(rx_bit_strobe));

   initial begin
      forever #5 clk = ~clk;
   end

   // Link bit clock, deliberately out of phase with clk
   initial begin
      #3;
      forever #80 tx_bit_strobe = ~tx_bit_strobe;
   end

   // Twenty bit slots per word; the word rate is scaled with clk, not in MHz
   always @(posedge tx_bit_strobe) begin
      bits <= (bits == 4'h9) ? 4'h0 : bits + 4'h1;
      if (bits == 4'h9) begin
         tx_word_clock <= ~tx_word_clock;
      end
   end

   task automatic check(input logic [17:0] seen, input logic [17:0] want);
      compares++;
      if (seen !== want) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic wrap_up;
      if (err_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic words(input int n);
      repeat (n) @(posedge tx_word_clock);
      @(negedge clk);
   endtask

   task automatic wait_lock(input logic want, input int limit);
      int n;
      n = 0;
      while (rx_lock_n !== want && n < limit) begin
         @(negedge clk);
         n++;
      end
      check(rx_lock_n, want);
   endtask

   task automatic t_reset;
      @(negedge clk);
      check(rx_lock_n, 1'b1);
      check(rx_word_oe, 1'b0);
      words(PLL - 1);
      check(tx_serial_oe, 1'b0);
      words(2);
      check(tx_serial_oe, 1'b1);
   endtask

   task automatic t_sync;
      sync_request = 1'b1;
      tx_word_in = 18'h0000F;
      wait_lock(1'b0, 12000);
      check(rx_word_out, serdes_pkg::SYNC_WORD);
      check(rx_clock_oe, 1'b1);
   endtask

   task automatic t_data;
      sync_request = 1'b0;
      for (int i = 0; i < 3; i++) begin
         tx_word_in = tab[i];
         // Capture, one frame out, one frame received: four word clocks
         words(4);
         check(rx_word_out, tab[i]);
         check(rx_lock_n, 1'b0);
      end
   endtask

   task automatic t_enable;
      rx_out_enable = 1'b0;
      settle(6);
      check(rx_clock_oe, 1'b0);
      rx_out_enable = 1'b1;
      settle(6);
      check(rx_word_oe, 1'b1);
      check(rx_word_out, 18'h0000F);
   endtask

   task automatic t_repeat;
      tx_sleep_n = 1'b0;
      settle(6);
      check(tx_serial_oe, 1'b0);
      wait_lock(1'b1, 2000);
      // Alternating bits break the source's pattern rule on purpose
      tx_word_in = 18'h2AAAA;
      tx_sleep_n = 1'b1;
      words(PLL - 1);
      check(tx_serial_oe, 1'b0);
      words(12);
      check(multi_edge_pattern, 1'b1);
      check(rx_lock_n, 1'b1);
      tx_word_in = 18'h3FFFF;
      wait_lock(1'b0, 12000);
      words(2);
      check(rx_word_out, 18'h3FFFF);
   endtask

   task automatic t_sleep;
      rx_sleep_n = 1'b0;
      settle(6);
      check(rx_serial_term, 1'b0);
      check(rx_lock_n, 1'b1);
      rx_sleep_n = 1'b1;
      // Lost lock asks the far transmitter for training patterns
      sync_request = rx_lock_n;
      settle(6);
      check(rx_lock_n, 1'b1);
      wait_lock(1'b0, 12000);
      check(rx_word_out, serdes_pkg::SYNC_WORD);
      sync_request = 1'b0;
   endtask

   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_sync();
      t_data();
      t_enable();
      t_repeat();
      t_sleep();
      wrap_up();
   end

   // About 20k cycles of work expected; three times that means a hang
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      wrap_up();
   end
endmodule // serdes_link_test
`default_nettype wire
